// ---- verification/hpp_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module hpp_host_model (
  // clock
  input  wire logic             i_core_clk,
  // port pins
  input  wire logic             i_port_ready_n,
  input  wire logic [15:0]      i_hd,
  output var hpp_pkg::hpp_hin_t o_host
);
  int timeouts = 0;

  initial begin
    o_host = '1;
    o_host.halfword_select = 1'b0;
  end

  // strobe one halfword, hold it until ready low, then release
  task automatic xfer(input logic rnw, input logic [1:0] at,
                      input logic hw, input logic [15:0] d,
                      output logic [15:0] q);
    int n;
    n = 0;
    @(posedge i_core_clk);
    o_host.cs_n <= 1'b0;
    o_host.ds1_n <= 1'b0;
    o_host.rnw <= rnw;
    o_host.access_type_sel <= at;
    o_host.halfword_select <= hw;
    o_host.data <= rnw ? ~o_host.data : d;
    do @(negedge i_core_clk) n++; while (i_port_ready_n !== 1'b1 && n < 100);
    if (n >= 100) timeouts++;
    do @(negedge i_core_clk) n++; while (i_port_ready_n !== 1'b0 && n < 2000);
    if (n >= 2000) timeouts++;
    q = i_hd;
    @(posedge i_core_clk);
    o_host.cs_n <= 1'b1;
    o_host.ds1_n <= 1'b1;
    // write data must outlive the release tick, then it is dropped
    repeat (24) @(posedge i_core_clk);
    o_host.data <= ~o_host.data;
  endtask

  task automatic wr32(input logic [1:0] at, input logic [31:0] d);
    logic [15:0] q;
    xfer(1'b0, at, 1'b0, d[15:0], q);
    xfer(1'b0, at, 1'b1, d[31:16], q);
  endtask

  task automatic rd32(input logic [1:0] at, output logic [31:0] d);
    xfer(1'b1, at, 1'b0, 16'h0, d[15:0]);
    xfer(1'b1, at, 1'b1, 16'h0, d[31:16]);
  endtask

  task automatic ctrl_wr(input logic [15:0] d);
    logic [15:0] q;
    xfer(1'b0, hpp_pkg::AT_CTRL, 1'b0, d, q);
  endtask
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic [7:0]         ra = 8'h00;
  logic [31:0]        wd = 32'h0;
  logic               we = 1'b0;
  logic               re = 1'b0;
  logic               ack = 1'b0;
  logic               hold = 1'b0;
  logic [1:0]         cnt = 2'h0;
  logic [31:0]        mem [16];
  logic [31:0]        mrd;
  logic [31:0]        rdata;
  logic [15:0]        hd;
  logic               hd_oe;
  logic               rdy_n;
  logic               irq_n;
  logic               cpu_irq;
  logic [31:0]        v;
  hpp_pkg::hpp_hin_t  hin;
  hpp_pkg::hpp_mreq_t mreq;
  int                 mismatches = 0;
  int                 check_count = 0;

  always #2.5 clk = ~clk;

  hpp_host_parallel_port_core dut (
    .i_core_clk(clk), .i_rst(rst), .i_host(hin), .o_hd(hd),
    .o_hd_oe(hd_oe), .o_port_ready_n(rdy_n), .o_host_irq_n(irq_n),
    .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_we(we), .i_reg_re(re),
    .o_reg_rdata(rdata), .o_cpu_irq(cpu_irq), .o_mem(mreq),
    .i_mem_ack(ack), .i_mem_rdata(mrd)
  );

  hpp_host_model host (
    .i_core_clk(clk), .i_port_ready_n(rdy_n), .i_hd(hd), .o_host(hin)
  );

  // between answers the read bus shows the inverse, not the last word
  assign mrd = ack ? mem[mreq.addr[5:2]] : ~mem[mreq.addr[5:2]];

  // memory answers each request three clocks late, stalls while held
  always @(posedge clk) begin
    ack <= 1'b0;
    if (mreq.req && !ack && !hold) begin
      cnt <= cnt + 2'h1;
      if (cnt == 2'h2) begin
        ack <= 1'b1;
        cnt <= 2'h0;
        if (mreq.we) mem[mreq.addr[5:2]] <= mreq.wdata;
      end
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude;
    mismatches += host.timeouts;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cpu_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic cpu_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    ra <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  // write fifo empty and memory quiet
  task automatic wait_idle;
    int n;
    n = 0;
    v = 32'h0;
    while (!(v[hpp_pkg::B_WEMP] === 1'b1 && mreq.req === 1'b0) && n < 100) begin
      cpu_rd(hpp_pkg::OFS_CTRL, v);
      n++;
    end
    if (n >= 100) begin
      mismatches++;
      conclude();
    end
  endtask

  task automatic t_reset;
    chk("ready_n", 32'h0, 32'(rdy_n));
    chk("host_irq_n", 32'h1, 32'(irq_n));
    chk("cpu_irq", 32'h0, 32'(cpu_irq));
    chk("hd_oe", 32'h0, 32'(hd_oe));
    chk("hd", 32'h0, 32'(hd));
    $display("t_reset done");
  endtask

  task automatic t_irq;
    cpu_wr(hpp_pkg::OFS_CTRL, 32'h4);
    chk("host_irq_n set", 32'h0, 32'(irq_n));
    host.xfer(1'b1, hpp_pkg::AT_CTRL, 1'b0, 16'h0, v[15:0]);
    chk("host ctrl view", 32'h0000_0104, 32'(v[15:0]));
    host.ctrl_wr(16'h0004);
    chk("host_irq_n ack", 32'h1, 32'(irq_n));
    host.ctrl_wr(16'h0002);
    chk("cpu_irq set", 32'h1, 32'(cpu_irq));
    cpu_wr(hpp_pkg::OFS_CTRL, 32'h2);
    chk("cpu_irq clr", 32'h0, 32'(cpu_irq));
    $display("t_irq done");
  endtask

  task automatic t_addr;
    host.wr32(hpp_pkg::AT_ADDR, 32'h1234_0020);
    cpu_rd(hpp_pkg::OFS_WADDR, v);
    chk("write addr", 32'h1234_0020, v);
    cpu_rd(hpp_pkg::OFS_RADDR, v);
    chk("read addr", 32'h1234_0020, v);
    host.rd32(hpp_pkg::AT_ADDR, v);
    chk("host addr read", 32'h1234_0020, v);
    host.ctrl_wr(16'h0001);
    host.wr32(hpp_pkg::AT_ADDR, 32'h1234_0030);
    cpu_rd(hpp_pkg::OFS_WADDR, v);
    chk("dual write addr", 32'h1234_0030, v);
    cpu_rd(hpp_pkg::OFS_RADDR, v);
    chk("dual read addr", 32'h1234_0020, v);
    host.ctrl_wr(16'h0041);
    host.wr32(hpp_pkg::AT_ADDR, 32'h1234_0040);
    cpu_rd(hpp_pkg::OFS_RADDR, v);
    chk("asel read addr", 32'h1234_0040, v);
    cpu_rd(hpp_pkg::OFS_WADDR, v);
    chk("asel write addr", 32'h1234_0030, v);
    host.ctrl_wr(16'h0000);
    $display("t_addr done");
  endtask

  task automatic t_data;
    host.wr32(hpp_pkg::AT_ADDR, 32'h1234_0010);
    host.wr32(hpp_pkg::AT_DATA, 32'hcafe_1357);
    wait_idle();
    chk("fixed write", 32'hcafe_1357, mem[4]);
    mem[5] = 32'h89ab_cdef;
    host.wr32(hpp_pkg::AT_ADDR, 32'h1234_0014);
    cpu_rd(hpp_pkg::OFS_CTRL, v);
    chk("no prefetch", 32'h0, 32'(v[hpp_pkg::B_RAVL]));
    host.rd32(hpp_pkg::AT_DATA, v);
    chk("fixed read", 32'h89ab_cdef, v);
    mem[6] = 32'h4567_0123;
    host.ctrl_wr(16'h0008);
    host.wr32(hpp_pkg::AT_ADDR, 32'h1234_0018);
    cpu_rd(hpp_pkg::OFS_CTRL, v);
    chk("prefetched", 32'h1, 32'(v[hpp_pkg::B_RAVL]));
    host.rd32(hpp_pkg::AT_DATA, v);
    chk("prefetch read", 32'h4567_0123, v);
    host.ctrl_wr(16'h0000);
    $display("t_data done");
  endtask

  task automatic t_burst;
    int k;
    host.wr32(hpp_pkg::AT_ADDR, 32'h1234_0020);
    for (k = 0; k < 3; k++) begin
      host.wr32(hpp_pkg::AT_DAUTO, 32'(32'h1111_0000 + k));
    end
    wait_idle();
    for (k = 0; k < 3; k++) begin
      chk("burst write", 32'(32'h1111_0000 + k), mem[8 + k]);
    end
    cpu_rd(hpp_pkg::OFS_WADDR, v);
    chk("addr after burst", 32'h1234_002c, v);
    host.wr32(hpp_pkg::AT_ADDR, 32'h1234_0020);
    for (k = 0; k < 3; k++) begin
      host.rd32(hpp_pkg::AT_DAUTO, v);
      chk("burst read", 32'(32'h1111_0000 + k), v);
    end
    // unread burst words are dropped after the idle limit
    host.ctrl_wr(16'h0010);
    repeat (1000) @(posedge clk);
    cpu_rd(hpp_pkg::OFS_CTRL, v);
    chk("burst kept", 32'h1, 32'(v[hpp_pkg::B_RAVL]));
    repeat (700) @(posedge clk);
    cpu_rd(hpp_pkg::OFS_CTRL, v);
    chk("burst dropped", 32'h0, 32'(v[hpp_pkg::B_RAVL]));
    cpu_rd(hpp_pkg::OFS_RADDR, v);
    chk("addr rewound", 32'h1234_002c, v);
    host.ctrl_wr(16'h0000);
    $display("t_burst done");
  endtask

  task automatic t_own;
    cpu_wr(hpp_pkg::OFS_WADDR, 32'h0000_0040);
    cpu_rd(hpp_pkg::OFS_WADDR, v);
    chk("waddr not owner", 32'h1234_0020, v);
    cpu_wr(hpp_pkg::OFS_CTRL, 32'h20);
    cpu_wr(hpp_pkg::OFS_WADDR, 32'h0000_0040);
    cpu_rd(hpp_pkg::OFS_WADDR, v);
    chk("waddr owner", 32'h0000_0040, v);
    host.wr32(hpp_pkg::AT_ADDR, 32'h0000_0080);
    cpu_rd(hpp_pkg::OFS_WADDR, v);
    chk("host addr refused", 32'h0000_0040, v);
    cpu_rd(8'hfc, v);
    chk("unmapped read", 32'h0, v);
    cpu_wr(hpp_pkg::OFS_CTRL, 32'h0);
    $display("t_own done");
  endtask

  // stalled memory lets the write fifo fill up
  task automatic t_full;
    int k;
    host.wr32(hpp_pkg::AT_ADDR, 32'h1234_0000);
    @(posedge clk);
    hold <= 1'b1;
    for (k = 0; k < 8; k++) begin
      host.wr32(hpp_pkg::AT_DAUTO, 32'(32'h2222_0000 + k));
    end
    fork
      host.wr32(hpp_pkg::AT_DAUTO, 32'h2222_0008);
      begin
        repeat (200) @(negedge clk);
        chk("ready while full", 32'h1, 32'(rdy_n));
        @(posedge clk);
        hold <= 1'b0;
      end
    join
    wait_idle();
    for (k = 0; k < 9; k++) begin
      chk("full burst", 32'(32'h2222_0000 + k), mem[k]);
    end
    cpu_rd(hpp_pkg::OFS_WADDR, v);
    chk("addr after full", 32'h1234_0024, v);
    $display("t_full done");
  endtask

  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = ~32'(i);
    end
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_reset();
    t_irq();
    t_addr();
    t_data();
    t_burst();
    t_own();
    t_full();
    conclude();
  end

  // hang guard, well under the cycle budget
  initial begin
    #300000;
    mismatches++;
    conclude();
  end

  always @(posedge clk) begin
    if (host.timeouts != 0) conclude();
  end
endmodule
`default_nettype wire

// ---- verilog/hpp_host_parallel_port_core.sv ----
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module hpp_host_parallel_port_core #(
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  // clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  // host pins
  input  wire hpp_pkg::hpp_hin_t i_host,
  output logic [15:0]            o_hd,
  output logic                   o_hd_oe,
  output logic                   o_port_ready_n,
  output logic                   o_host_irq_n,
  // cpu register port
  input  wire logic [7:0]        i_reg_addr,
  input  wire logic [31:0]       i_reg_wdata,
  input  wire logic              i_reg_we,
  input  wire logic              i_reg_re,
  output logic [31:0]            o_reg_rdata,
  output logic                   o_cpu_irq,
  // memory side
  output hpp_pkg::hpp_mreq_t     o_mem,
  input  wire logic              i_mem_ack,
  input  wire logic [31:0]       i_mem_rdata
);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [2:0]              div;
    hpp_pkg::hpp_hin_t       s1;
    hpp_pkg::hpp_hin_t       s2;
    logic                    stb_q;
    hpp_pkg::hpp_hst_t       st;
    logic [1:0]              at;
    logic                    rnw;
    logic                    hws;
    logic                    done;
    logic [15:0]             shared_ctrl;
    logic [31:0]             read_addr;
    logic [31:0]             write_addr;
    logic [15:0]             alo;
    logic [15:0]             wlo;
    logic [31:0]             data_hold;
    logic [DEPTH-1:0][32:0]  wf;
    logic [AW:0]             wcnt;
    logic [AW-1:0]           wrp;
    logic [AW-1:0]           wwp;
    logic [DEPTH-1:0][31:0]  rf;
    logic [AW:0]             rcnt;
    logic [AW-1:0]           rrp;
    logic [AW-1:0]           rwp;
    logic                    rd_on;
    logic                    rd_auto;
    logic                    drop;
    logic [15:0]             tmo;
    hpp_pkg::hpp_mst_t       ms;
    hpp_pkg::hpp_mreq_t      mem;
    logic [15:0]             hd;
    logic                    oe;
    logic                    ready_n;
    logic                    irq_n;
    logic [31:0]             rdata;
  } hpp_state_t;

  hpp_state_t r;
  hpp_state_t n;

  logic        ce;
  logic        stb;
  logic        own_cpu;
  logic        ok;
  logic        wpush;
  logic        wpop;
  logic        rpush;
  logic        rpop;
  logic        wa_ld;
  logic        ra_ld;
  logic        wa_inc;
  logic        ra_inc;
  logic        rflush;
  logic        tmo_hit;
  logic        ha_both;
  logic        cpu_hset;
  logic        cpu_cclr;
  logic        host_cset;
  logic        host_hclr;
  logic [31:0] a_val;
  logic [32:0] w_ent;

  function automatic logic [15:0] f_half(input logic [31:0] w,
                                         input logic        hi);
    f_half = hi ? w[31:16] : w[15:0];
  endfunction

  function automatic logic [15:0] f_view(input hpp_state_t s);
    f_view = s.shared_ctrl;
    f_view[hpp_pkg::B_WEMP] = (s.wcnt == '0);
    f_view[hpp_pkg::B_RAVL] = (s.rcnt != '0);
  endfunction

  always_comb begin
    n         = r;
    ok        = 1'b0;
    wpush     = 1'b0;
    wpop      = 1'b0;
    rpush     = 1'b0;
    rpop      = 1'b0;
    wa_ld     = 1'b0;
    ra_ld     = 1'b0;
    wa_inc    = 1'b0;
    ra_inc    = 1'b0;
    ha_both   = 1'b0;
    tmo_hit   = 1'b0;
    cpu_hset  = 1'b0;
    cpu_cclr  = 1'b0;
    host_cset = 1'b0;
    host_hclr = 1'b0;
    a_val     = i_reg_wdata;
    w_ent     = {r.at == hpp_pkg::AT_DAUTO, r.s2.data, r.wlo};
    ce        = (r.div == hpp_pkg::DIV_LAST); // [RL17]
    n.div     = ce ? 3'h0 : r.div + 3'h1;
    // host pins are asynchronous: two flops before any use
    n.s1      = i_host; // [RL17]
    n.s2      = r.s1;
    stb       = ~r.s2.cs_n & (r.s2.ds1_n ^ r.s2.ds2_n);
    own_cpu   = r.shared_ctrl[hpp_pkg::B_OWN];
    n.rdata   = 32'h0;

    if (i_reg_re) begin
      case (i_reg_addr)
        hpp_pkg::OFS_CTRL:  n.rdata = {16'h0, f_view(r)}; // [RL13]
        hpp_pkg::OFS_WADDR: n.rdata = r.write_addr;
        hpp_pkg::OFS_RADDR: n.rdata = r.read_addr;
        default:            n.rdata = 32'h0;
      endcase
    end
    if (i_reg_we) begin
      case (i_reg_addr)
        hpp_pkg::OFS_CTRL: begin
          cpu_hset = i_reg_wdata[hpp_pkg::B_HIRQ]; // [RL13]
          cpu_cclr = i_reg_wdata[hpp_pkg::B_CIRQ]; // [RL13]
          n.shared_ctrl[hpp_pkg::B_OWN] = i_reg_wdata[hpp_pkg::B_OWN]; // [RL16]
          if (own_cpu) begin
            n.shared_ctrl = (n.shared_ctrl & ~hpp_pkg::CFG_MASK) |
                            (i_reg_wdata[15:0] & hpp_pkg::CFG_MASK);
          end
        end
        hpp_pkg::OFS_WADDR: wa_ld = own_cpu; // [RL16]
        hpp_pkg::OFS_RADDR: ra_ld = own_cpu; // [RL16]
        default: ;
      endcase
    end

    if (ce) begin
      n.stb_q = stb;
      case (r.st)
        hpp_pkg::HS_IDLE: begin
          n.oe      = 1'b0;
          n.ready_n = 1'b0;
          if (stb && !r.stb_q) begin
            n.at      = r.s2.access_type_sel; // [RL19]
            n.rnw     = r.s2.rnw;
            n.hws     = r.s2.halfword_select; // [RL20]
            n.done    = 1'b0;
            n.ready_n = 1'b1; // [RL12]
            n.st      = hpp_pkg::HS_ACT;
          end
        end
        hpp_pkg::HS_ACT: begin
          if (!stb) begin
            // write data is taken as the strobe ends
            if (!r.rnw && r.done) begin
              case (r.at)
                hpp_pkg::AT_CTRL: begin
                  if (!r.hws) begin
                    host_cset = r.s2.data[hpp_pkg::B_CIRQ]; // [RL14]
                    host_hclr = r.s2.data[hpp_pkg::B_HIRQ]; // [RL22]
                    if (!own_cpu) begin
                      n.shared_ctrl = (n.shared_ctrl & ~hpp_pkg::CFG_MASK) |
                                      (r.s2.data & hpp_pkg::CFG_MASK); // [RL14]
                    end
                  end
                end
                hpp_pkg::AT_ADDR: begin
                  if (!r.hws) begin
                    n.alo = r.s2.data;
                  end else if (!own_cpu) begin
                    a_val = {r.s2.data, r.alo}; // [RL3] [RL6]
                    if (!r.shared_ctrl[hpp_pkg::B_DUAL]) begin
                      wa_ld   = 1'b1; // [RL5]
                      ra_ld   = 1'b1;
                      ha_both = 1'b1;
                    end else if (r.shared_ctrl[hpp_pkg::B_ASEL]) begin
                      ra_ld = 1'b1; // [RL4]
                    end else begin
                      wa_ld = 1'b1; // [RL4]
                    end
                  end
                end
                default: begin
                  if (!r.hws) begin
                    n.wlo = r.s2.data; // [RL1]
                  end else begin
                    wpush = 1'b1; // [RL6] [RL7]
                  end
                end
              endcase
            end
            n.oe      = 1'b0;
            n.ready_n = 1'b0;
            n.st      = hpp_pkg::HS_IDLE;
          end else if (!r.done) begin
            if (!r.rnw) begin
              if (r.hws && r.at == hpp_pkg::AT_DAUTO) begin
                ok = (r.wcnt != FULL); // [RL10]
              end else if (r.hws && r.at == hpp_pkg::AT_DATA) begin
                ok = (r.wcnt == '0); // [RL11]
              end else begin
                ok = 1'b1;
              end
            end else begin
              case (r.at)
                hpp_pkg::AT_CTRL: begin
                  ok   = 1'b1;
                  n.hd = f_view(r);
                end
                hpp_pkg::AT_ADDR: begin
                  ok   = 1'b1;
                  n.hd = f_half(r.read_addr, r.hws);
                end
                default: begin
                  if (r.hws) begin
                    ok   = 1'b1;
                    n.hd = r.data_hold[31:16]; // [RL8]
                  end else begin
                    ok = (r.rcnt != '0);
                    if (ok) begin
                      rpop        = 1'b1;
                      n.data_hold = r.rf[r.rrp]; // [RL8]
                      n.hd        = r.rf[r.rrp][15:0]; // [RL18]
                    end else if (!r.rd_on) begin
                      n.rd_on   = 1'b1;
                      n.rd_auto = (r.at == hpp_pkg::AT_DAUTO);
                    end
                  end
                end
              endcase
            end
            if (ok) begin
              n.done    = 1'b1;
              n.ready_n = 1'b0; // [RL21]
              n.oe      = r.rnw; // [RL2]
            end
          end
        end
        default: n.st = hpp_pkg::HS_IDLE;
      endcase
      // unread burst data goes stale while the host is away
      if (r.shared_ctrl[hpp_pkg::B_TMO] && r.rcnt != '0 &&
          r.rd_auto && r.st == hpp_pkg::HS_IDLE) begin
        n.tmo = r.tmo + 16'h1;
        if (r.tmo == hpp_pkg::TMO_TICKS && r.ms != hpp_pkg::MS_RD) begin
          tmo_hit = 1'b1; // [RL16]
        end
      end else begin
        n.tmo = 16'h0;
      end
    end

    case (r.ms)
      hpp_pkg::MS_IDLE: begin
        if (r.wcnt != '0) begin
          n.mem = {1'b1, 1'b1, r.write_addr, r.wf[r.wrp][31:0]}; // [RL7]
          n.ms  = hpp_pkg::MS_WR;
        end else if (r.rd_on &&
                     (r.rd_auto ? r.rcnt != FULL : r.rcnt == '0)) begin
          n.mem = {1'b1, 1'b0, r.read_addr, 32'h0}; // [RL10] [RL11]
          n.ms  = hpp_pkg::MS_RD;
          if (!r.rd_auto) begin
            n.rd_on = 1'b0;
          end
        end
      end
      hpp_pkg::MS_WR: begin
        if (i_mem_ack) begin
          n.mem.req = 1'b0;
          wpop      = 1'b1;
          wa_inc    = r.wf[r.wrp][32]; // [RL10]
          n.ms      = hpp_pkg::MS_IDLE;
        end
      end
      hpp_pkg::MS_RD: begin
        if (i_mem_ack) begin
          n.mem.req = 1'b0;
          rpush     = !r.drop;
          ra_inc    = r.rd_auto && !r.drop;
          n.drop    = 1'b0;
          n.ms      = hpp_pkg::MS_IDLE;
        end
      end
      default: n.ms = hpp_pkg::MS_IDLE;
    endcase

    if (wa_ld) begin
      n.write_addr = a_val;
    end else if (wa_inc) begin
      n.write_addr = r.write_addr + hpp_pkg::ADDR_STEP;
    end
    rflush = ra_ld | tmo_hit;
    if (ra_ld) begin
      n.read_addr = a_val;
      n.rd_on     = r.shared_ctrl[hpp_pkg::B_PREF]; // [RL15]
      n.rd_auto   = 1'b0;
    end else if (tmo_hit) begin
      // rewind so the dropped words are fetched again later
      n.read_addr = r.read_addr - 32'({r.rcnt, 2'b00});
      n.rd_on     = 1'b0;
    end else if (ra_inc) begin
      n.read_addr = r.read_addr + hpp_pkg::ADDR_STEP;
    end

    if (wpush) begin
      n.wf[r.wwp] = w_ent;
      n.wwp       = r.wwp + 1'b1;
    end
    if (wpop) begin
      n.wrp = r.wrp + 1'b1;
    end
    n.wcnt = r.wcnt + {{AW{1'b0}}, wpush} - {{AW{1'b0}}, wpop}; // [RL9]
    if (rflush) begin
      n.rcnt = '0;
      n.rrp  = '0;
      n.rwp  = '0;
      n.drop = (n.ms == hpp_pkg::MS_RD);
    end else begin
      if (rpush) begin
        n.rf[r.rwp] = i_mem_rdata; // [RL18]
        n.rwp       = r.rwp + 1'b1;
      end
      if (rpop) begin
        n.rrp = r.rrp + 1'b1;
      end
      n.rcnt = r.rcnt + {{AW{1'b0}}, rpush} - {{AW{1'b0}}, rpop}; // [RL9]
    end

    // a set in the same cycle as the clear wins
    n.shared_ctrl[hpp_pkg::B_HIRQ] = cpu_hset |
      (r.shared_ctrl[hpp_pkg::B_HIRQ] & ~host_hclr); // [RL13] [RL22]
    n.shared_ctrl[hpp_pkg::B_CIRQ] = host_cset |
      (r.shared_ctrl[hpp_pkg::B_CIRQ] & ~cpu_cclr); // [RL14]
    n.irq_n = ~n.shared_ctrl[hpp_pkg::B_HIRQ]; // [RL22]
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      r               <= '0;
      r.st            <= hpp_pkg::HS_IDLE;
      r.ms            <= hpp_pkg::MS_IDLE;
      r.shared_ctrl   <= hpp_pkg::CTRL_RST;
      r.read_addr     <= hpp_pkg::ADDR_RST;
      r.write_addr    <= hpp_pkg::ADDR_RST;
      r.irq_n         <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign o_hd           = r.hd;
  assign o_hd_oe        = r.oe;
  assign o_port_ready_n = r.ready_n;
  assign o_host_irq_n   = r.irq_n;
  assign o_reg_rdata    = r.rdata;
  assign o_cpu_irq      = r.shared_ctrl[hpp_pkg::B_CIRQ];
  assign o_mem          = r.mem;

  div_pulse_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RL17]
    ce |=> !ce [*5] ##1 ce)
    else $error("port tick spacing wrong");
  irq_set_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RL22]
    (i_reg_we && i_reg_addr == hpp_pkg::OFS_CTRL &&
     i_reg_wdata[hpp_pkg::B_HIRQ]) |=> !o_host_irq_n)
    else $error("host irq pin not asserted");
  cpu_irq_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RL14]
    host_cset |=> o_cpu_irq)
    else $error("cpu irq not raised by host");
  ready_wait_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RL12]
    (ce && r.st == hpp_pkg::HS_IDLE && stb && !r.stb_q) |=> o_port_ready_n)
    else $error("ready not withheld at strobe start");
  wr_full_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RL10]
    (r.st == hpp_pkg::HS_ACT && !r.rnw && r.hws && !r.done &&
     r.at == hpp_pkg::AT_DAUTO && r.wcnt == FULL) |=> o_port_ready_n)
    else $error("ready granted with write fifo full");
  single_ent_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RL11]
    !r.rd_auto |-> r.rcnt <= 1)
    else $error("non-burst read uses more than one entry");
  fifo_bound_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RL9]
    r.wcnt <= FULL && r.rcnt <= FULL)
    else $error("fifo count beyond depth");
  addr_both_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RL5]
    ha_both |=> r.read_addr == r.write_addr)
    else $error("single address mode registers differ");
  rd_oe_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RL2]
    o_hd_oe |-> (r.rnw && r.st == hpp_pkg::HS_ACT))
    else $error("data bus driven outside a read");
  mem_wr_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RL7]
    (r.ms == hpp_pkg::MS_WR && i_mem_ack) |=> (!o_mem.req && wpop == 1'b0))
    else $error("write request not retired on ack");
endmodule
`default_nettype wire

// ---- verilog/hpp_pkg.sv ----
// Function
// RL1 - each host cycle is two halfword transfers; control accesses here take a single halfword
// RL2 - one bus carries addresses and data
// RL3 - host address captured into 32-bit register
// RL4 - separate read and write address registers
// RL5 - option merges both address registers for host
// RL6 - 32-bit word built from two halfwords
// RL7 - write data held until stored to memory
// RL8 - read data held until host takes it
// RL9 - read and write fifos, eight words each
// RL10 - fifos buffer bursts during autoincrement
// RL11 - without autoincrement only one entry used
// RL12 - ready withheld while port is busy
// RL13 - cpu raises host irq, clears its own
// RL14 - host configures, raises cpu irq, clears its
// RL15 - software controls read prefetch
// RL16 - ownership and fifo timeout set by register
// RL17 - divide-by-six port clock, host asynchronous
// RL18 - no byte swapping of any kind
// RL19 - access type latched at strobe fall
// RL20 - halfword select low first, high second
// RL21 - ready active low
// RL22 - irq pin low while bit set, write-one clears
`default_nettype none
package hpp_pkg;
  localparam int         PORT_DIV  = 6;
  localparam logic [2:0] DIV_LAST  = 3'(PORT_DIV - 1);
  // cpu register offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_WADDR = 8'h04;
  localparam logic [7:0] OFS_RADDR = 8'h08;
  // shared control register fields
  localparam int B_DUAL = 0;
  localparam int B_CIRQ = 1;
  localparam int B_HIRQ = 2;
  localparam int B_PREF = 3;
  localparam int B_TMO  = 4;
  localparam int B_OWN  = 5;
  localparam int B_ASEL = 6;
  localparam int B_WEMP = 8;
  localparam int B_RAVL = 9;
  localparam logic [15:0] CFG_MASK  = 16'h0059;
  localparam logic [15:0] CTRL_RST  = 16'h0000;
  localparam logic [31:0] ADDR_RST  = 32'h0000_0000;
  localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
  // access_type_sel codes
  localparam logic [1:0] AT_CTRL  = 2'h0;
  localparam logic [1:0] AT_DAUTO = 2'h1;
  localparam logic [1:0] AT_ADDR  = 2'h2;
  localparam logic [1:0] AT_DATA  = 2'h3;
  // idle port ticks before unread burst prefetch is dropped
  localparam logic [15:0] TMO_TICKS = 16'h0100;

  typedef struct packed {
    logic        cs_n;
    logic        ds1_n;
    logic        ds2_n;
    logic        rnw;
    logic        halfword_select;
    logic [1:0]  access_type_sel;
    logic [15:0] data;
  } hpp_hin_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } hpp_mreq_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b01,
    HS_ACT  = 2'b10
  } hpp_hst_t;

  typedef enum logic [2:0] {
    MS_IDLE = 3'b001,
    MS_WR   = 3'b010,
    MS_RD   = 3'b100
  } hpp_mst_t;
endpackage
`default_nettype wire
